// ==== design/cpg_top.sv ====
// canopen port configuration, sync/emcy identifiers and node guarding supervision
// assumes the can controller hands over one-cycle guard request pulses on core_clk;
// dip switches are asynchronous pins; nonvolatile storage of stored values lies outside
`timescale 1ns/100ps

module cpg_top
  import cpg_pkg::*;
#(
  parameter int MS_CYCLES_P = cpg_pkg::MS_CYCLES
)
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // parameter access
  input  wire cpg_pkg::cpg_req_t par_req,
  output      cpg_pkg::cpg_rsp_t par_rsp,
  // dip switch pins
  input  wire logic [6:0]       dip_node,
  input  wire logic [2:0]       dip_rate,
  // guarding with the can controller
  input  wire logic             guard_req,
  output      logic             guard_reply,
  output      logic             guard_fault,
  // configuration in use
  output      cpg_pkg::cpg_cfg_t port_cfg,
  // group entry counts
  output      logic [7:0]       status_group_count,
  output      logic [7:0]       stored_group_count,
  output      logic [7:0]       active_group_count
);
  import cpg_pkg::*;

  typedef struct packed {
    logic [1:0]  rst_sync;
    logic [6:0]  dn0;
    logic [6:0]  dn1;
    logic [6:0]  dn2;
    logic [2:0]  dr0;
    logic [2:0]  dr1;
    logic [2:0]  dr2;
    logic [6:0]  dip_node_ok;
    logic [2:0]  dip_rate_ok;
    cpg_phase_t  phase;
    logic [2:0]  settle_cnt;
    logic [15:0] port_enable;
    logic [15:0] source_sel;
    logic [15:0] stored_node;
    logic [31:0] stored_rate;
    logic [31:0] sync_period;
    logic [15:0] guard_time;
    logic [7:0]  life_mult;
    logic [15:0] ms_cnt;
    logic        armed;
    logic [23:0] life_cnt;
    logic        guard_reply;
    logic        guard_fault;
    cpg_cfg_t    cfg;
    cpg_rsp_t    rsp;
    logic [7:0]  count;
  } cpg_state_t;

  //////////////////////////////////////////////////////////////////////////////

  function automatic logic addr_known(input logic [15:0] a);
    case (a)
      OFS_PORT_ENABLE, OFS_SOURCE_SEL, OFS_STORED_NODE, OFS_STORED_RATE, OFS_ACTIVE_NODE,
      OFS_ACTIVE_RATE, OFS_SYNC_ID, OFS_SYNC_PERIOD, OFS_GUARD_TIME, OFS_LIFE_MULT,
      OFS_EMCY_ID: addr_known = 1'b1;
      default:     addr_known = 1'b0;
    endcase
  endfunction

  function automatic cpg_state_t init_state();
    cpg_state_t t;
    t = '0;
    t.phase       = PH_SETTLE;
    t.port_enable = RST_PORT_ENABLE;
    t.source_sel  = RST_SOURCE_SEL;
    t.stored_node = RST_STORED_NODE;
    t.stored_rate = RST_STORED_RATE;
    t.cfg.sync_id = RST_SYNC_ID;
    t.count       = GROUP_COUNT;
    return t;
  endfunction

  cpg_state_t s;
  cpg_state_t next_s;
  logic [23:0] timeout;
  logic        ms_tick;
  logic        use_stored;
  logic        wr_ok;

  // widen before multiplying so a long guard interval cannot wrap the product
  assign timeout    = 24'(s.guard_time) * 24'(s.life_mult);
  assign ms_tick    = (s.ms_cnt == 16'(MS_CYCLES_P - 1));
  // a zero dip node number hands the setup over to the stored values
  assign use_stored = (s.source_sel == SOURCE_STORED) || (s.dip_node_ok == 7'h00);

  //////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    next_s = s;
    next_s.rst_sync = {s.rst_sync[0], 1'b1};
    next_s.dn0 = dip_node;
    next_s.dn1 = s.dn0;
    next_s.dn2 = s.dn1;
    next_s.dr0 = dip_rate;
    next_s.dr1 = s.dr0;
    next_s.dr2 = s.dr1;
    if (s.dn1 == s.dn2)
      next_s.dip_node_ok = s.dn2;
    if (s.dr1 == s.dr2)
      next_s.dip_rate_ok = s.dr2;
    next_s.guard_reply = 1'b0;
    next_s.rsp.ack     = 1'b0;
    next_s.rsp.err     = 1'b0;
    wr_ok = 1'b0;

    case (s.phase)
      PH_SETTLE:
      begin
        // wait for the dip synchronisers to fill before latching the setup
        next_s.settle_cnt = s.settle_cnt + 3'h1;
        if (s.settle_cnt == CFG_SETTLE_CYCLES)
        begin
          next_s.phase = PH_RUN;
          if (use_stored)
          begin
            next_s.cfg.node = s.stored_node;
            next_s.cfg.rate = s.stored_rate;
          end
          else
          begin
            next_s.cfg.node = {9'h000, s.dip_node_ok};
            next_s.cfg.rate = cpg_rate_of(s.dip_rate_ok);
          end
          next_s.cfg.emcy_id = EMCY_BASE + {16'h0000, next_s.cfg.node};
        end
      end
      PH_RUN:
      begin
        if (par_req.wr || par_req.rd)
        begin
          next_s.rsp.ack   = 1'b1;
          next_s.rsp.rdata = 32'h00000000;
          next_s.rsp.err   = !addr_known(par_req.addr);
        end
        if (par_req.wr)
        begin
          case (par_req.addr)
            OFS_PORT_ENABLE:
            begin
              wr_ok = 1'b1;
              next_s.port_enable = par_req.wdata[15:0];
            end
            OFS_SOURCE_SEL:
            begin
              wr_ok = (par_req.wdata <= {16'h0000, SOURCE_STORED});
              if (wr_ok)
                next_s.source_sel = par_req.wdata[15:0];
            end
            OFS_STORED_NODE:
            begin
              wr_ok = (par_req.wdata >= {16'h0000, NODE_MIN}) && (par_req.wdata <= {16'h0000, NODE_MAX});
              if (wr_ok)
                next_s.stored_node = par_req.wdata[15:0];
            end
            OFS_STORED_RATE:
            begin
              wr_ok = cpg_rate_ok(par_req.wdata);
              if (wr_ok)
                next_s.stored_rate = par_req.wdata;
            end
            OFS_SYNC_ID:
            begin
              wr_ok = 1'b1;
              next_s.cfg.sync_id = par_req.wdata;
            end
            OFS_SYNC_PERIOD:
            begin
              wr_ok = (par_req.wdata <= SYNC_PERIOD_MAX);
              if (wr_ok)
                next_s.sync_period = par_req.wdata;
            end
            OFS_GUARD_TIME:
            begin
              wr_ok = 1'b1;
              next_s.guard_time = par_req.wdata[15:0];
            end
            OFS_LIFE_MULT:
            begin
              wr_ok = 1'b1;
              next_s.life_mult = par_req.wdata[7:0];
            end
            OFS_EMCY_ID:
            begin
              wr_ok = 1'b1;
              // a valid identifier keeps its id bits; only bits 30 and 31 move
              if (!s.cfg.emcy_id[EMCY_VALID_BIT])
                next_s.cfg.emcy_id[31:30] = par_req.wdata[31:30];
              else
                next_s.cfg.emcy_id = par_req.wdata;
            end
            default:
              wr_ok = 1'b0;
          endcase
          next_s.rsp.err = !wr_ok;
        end
        else if (par_req.rd)
        begin
          case (par_req.addr)
            OFS_PORT_ENABLE: next_s.rsp.rdata = {16'h0000, s.port_enable};
            OFS_SOURCE_SEL:  next_s.rsp.rdata = {16'h0000, s.source_sel};
            OFS_STORED_NODE: next_s.rsp.rdata = {16'h0000, s.stored_node};
            OFS_STORED_RATE: next_s.rsp.rdata = s.stored_rate;
            OFS_ACTIVE_NODE: next_s.rsp.rdata = {16'h0000, s.cfg.node};
            OFS_ACTIVE_RATE: next_s.rsp.rdata = s.cfg.rate;
            OFS_SYNC_ID:     next_s.rsp.rdata = s.cfg.sync_id;
            OFS_SYNC_PERIOD: next_s.rsp.rdata = s.sync_period;
            OFS_GUARD_TIME:  next_s.rsp.rdata = {16'h0000, s.guard_time};
            OFS_LIFE_MULT:   next_s.rsp.rdata = {24'h000000, s.life_mult};
            OFS_EMCY_ID:     next_s.rsp.rdata = s.cfg.emcy_id;
            default:         next_s.rsp.rdata = 32'h00000000;
          endcase
        end

        // node guarding: supervision starts with the first request
        next_s.ms_cnt = ms_tick ? 16'h0000 : s.ms_cnt + 16'h0001;
        if (guard_req && s.cfg.port_on)
        begin
          next_s.guard_reply = 1'b1;
          next_s.armed       = 1'b1;
          next_s.life_cnt    = 24'h000000;
          next_s.ms_cnt      = 16'h0000;
        end
        else if (s.armed && s.cfg.port_on && timeout != 24'h000000 && ms_tick)
        begin
          next_s.life_cnt = s.life_cnt + 24'h000001;
          if (s.life_cnt + 24'h000001 >= timeout)
            next_s.guard_fault = 1'b1;
        end
      end
      default:
        next_s.phase = PH_SETTLE;
    endcase

    // derived outputs follow the registered configuration
    next_s.cfg.port_on    = (next_s.port_enable != 16'h0000);
    next_s.cfg.sync_rx_en = next_s.cfg.port_on && (next_s.sync_period != 32'h00000000);
    next_s.cfg.emcy_tx_en = next_s.cfg.port_on && !next_s.cfg.emcy_id[EMCY_VALID_BIT]
                            && (next_s.phase == PH_RUN);

    if (!s.rst_sync[1])
    begin
      next_s = init_state();
      next_s.rst_sync = {s.rst_sync[0], 1'b1};
      next_s.dn0 = dip_node;
      next_s.dn1 = s.dn0;
      next_s.dn2 = s.dn1;
      next_s.dr0 = dip_rate;
      next_s.dr1 = s.dr0;
      next_s.dr2 = s.dr1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign par_rsp            = s.rsp;
  assign guard_reply        = s.guard_reply;
  assign guard_fault        = s.guard_fault;
  assign port_cfg           = s.cfg;
  assign status_group_count = s.count;
  assign stored_group_count = s.count;
  assign active_group_count = s.count;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!s.rst_sync[1]);

  a_guard_answer: assert property (
    (s.phase == PH_RUN && guard_req && s.cfg.port_on) |=> guard_reply)
    else $error("guard request not answered");
  a_reply_cause: assert property (
    guard_reply |-> $past(guard_req) && $past(s.cfg.port_on))
    else $error("guard reply without request");
  a_node_reject: assert property (
    (s.phase == PH_RUN && par_req.wr && par_req.addr == OFS_STORED_NODE
     && par_req.wdata > {16'h0000, NODE_MAX}) |=> $stable(s.stored_node) && par_rsp.err)
    else $error("out-of-range node number accepted");
  a_rate_reject: assert property (
    (s.phase == PH_RUN && par_req.wr && par_req.addr == OFS_STORED_RATE
     && !cpg_rate_ok(par_req.wdata)) |=> $stable(s.stored_rate))
    else $error("illegal bit rate accepted");
  a_emcy_lock: assert property (
    (par_req.wr && par_req.addr == OFS_EMCY_ID && !s.cfg.emcy_id[EMCY_VALID_BIT])
    |=> s.cfg.emcy_id[EMCY_LOCK_MSB:0] == $past(s.cfg.emcy_id[EMCY_LOCK_MSB:0]))
    else $error("emergency id changed while valid");
  a_sync_gate: assert property (
    port_cfg.sync_rx_en |-> s.sync_period != 32'h00000000 && s.sync_period <= SYNC_PERIOD_MAX)
    else $error("sync reception enabled with zero period");
  a_active_hold: assert property (
    (s.phase == PH_RUN) |=> $stable(port_cfg.node) && $stable(port_cfg.rate))
    else $error("active setup changed without reset");
  a_node_range: assert property (
    (s.phase == PH_RUN) |-> port_cfg.node >= NODE_MIN && port_cfg.node <= NODE_MAX)
    else $error("active node number out of range");
  a_fault_time: assert property (
    $rose(guard_fault) |-> $past(s.armed) && s.life_cnt >= timeout && timeout != 24'h000000)
    else $error("guard fault before timeout");
  a_port_off: assert property (
    (s.port_enable == 16'h0000) |-> !port_cfg.port_on && !port_cfg.emcy_tx_en)
    else $error("port active while disabled");
  a_group_count: assert property (
    status_group_count == GROUP_COUNT && active_group_count == GROUP_COUNT)
    else $error("group count not two");

endmodule

// ==== include/cpg_pkg.sv ====
// constants and carrier types for the canopen port configuration and guarding block
// assumes a single 40 mhz core clock and a word-wide parameter access port
package cpg_pkg;

  // parameter addresses, one entry per parameter
  localparam logic [15:0] OFS_PORT_ENABLE   = 16'h03e8;
  localparam logic [15:0] OFS_SOURCE_SEL    = 16'h03e9;
  localparam logic [15:0] OFS_STORED_NODE   = 16'h03ea;
  localparam logic [15:0] OFS_STORED_RATE   = 16'h03eb;
  localparam logic [15:0] OFS_ACTIVE_NODE   = 16'h03ed;
  localparam logic [15:0] OFS_ACTIVE_RATE   = 16'h03ee;
  localparam logic [15:0] OFS_SYNC_ID       = 16'h03f2;
  localparam logic [15:0] OFS_SYNC_PERIOD   = 16'h03f4;
  localparam logic [15:0] OFS_GUARD_TIME    = 16'h03f6;
  localparam logic [15:0] OFS_LIFE_MULT     = 16'h03f7;
  localparam logic [15:0] OFS_EMCY_ID       = 16'h03f8;

  // reset values
  localparam logic [15:0] RST_PORT_ENABLE   = 16'h0001;
  localparam logic [15:0] RST_SOURCE_SEL    = 16'h0000;
  localparam logic [15:0] RST_STORED_NODE   = 16'h0001;
  localparam logic [31:0] RST_STORED_RATE   = 32'h000f4240;
  localparam logic [31:0] RST_SYNC_ID       = 32'h00000080;
  localparam logic [31:0] EMCY_BASE         = 32'h00000080;
  localparam logic [7:0]  GROUP_COUNT       = 8'h02;

  // ranges and fields
  localparam logic [15:0] SOURCE_STORED     = 16'h0001;
  localparam logic [15:0] NODE_MIN          = 16'h0001;
  localparam logic [15:0] NODE_MAX          = 16'h007f;
  localparam logic [31:0] SYNC_PERIOD_MAX   = 32'h00007d00;
  localparam int          EMCY_VALID_BIT    = 31;
  localparam int          EMCY_LOCK_MSB     = 29;

  // timing: guard time counts in milliseconds
  localparam int          CLK_PERIOD_NS     = 25;
  localparam int          GUARD_UNIT_NS     = 1000000;
  localparam int          MS_CYCLES         = GUARD_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [2:0]  CFG_SETTLE_CYCLES = 3'h4;

  // bit rate code from the dip switches
  function automatic logic [31:0] cpg_rate_of(input logic [2:0] code);
    case (code)
      3'h0:    cpg_rate_of = 32'h00004e20;
      3'h1:    cpg_rate_of = 32'h0000c350;
      3'h2:    cpg_rate_of = 32'h000186a0;
      3'h3:    cpg_rate_of = 32'h0001e848;
      3'h4:    cpg_rate_of = 32'h0003d090;
      3'h5:    cpg_rate_of = 32'h0007a120;
      default: cpg_rate_of = 32'h000f4240;
    endcase
  endfunction

  function automatic logic cpg_rate_ok(input logic [31:0] rate);
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < 7; i++)
      if (rate == cpg_rate_of(3'(i)))
        ok = 1'b1;
    cpg_rate_ok = ok;
  endfunction

  typedef enum logic {PH_SETTLE, PH_RUN} cpg_phase_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } cpg_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } cpg_rsp_t;

  typedef struct packed {
    logic        port_on;
    logic [15:0] node;
    logic [31:0] rate;
    logic [31:0] sync_id;
    logic        sync_rx_en;
    logic [31:0] emcy_id;
    logic        emcy_tx_en;
  } cpg_cfg_t;

endpackage

// ==== verification/cpg_master_model.sv ====
// stand-in for the network master: node guarding requests at a fixed gap
// assumes the block's core clock; counts requests sent and replies seen
`timescale 1ns/100ps
module cpg_master_model
(
  // clock
  input  wire logic core_clk,
  // bench control
  input  wire logic run,
  input  wire logic [31:0] gap,
  // guarding exchange
  output      logic guard_req,
  input  wire logic guard_reply,
  output      int   n_req,
  output      int   n_reply
);
  int   wait_cnt = 0;
  logic run_q;
  logic fire;
  initial
  begin
    guard_req = 1'b0;
    n_req = 0;
    n_reply = 0;
  end
  // run is sampled on the edge so a bench change at the same delay cannot race it
  always @(posedge core_clk)
  begin
    run_q = run;
    #1;
    if (guard_reply === 1'b1)
      n_reply++;
    fire = run_q && (wait_cnt + 1 >= gap);
    wait_cnt = (fire || !run_q) ? 0 : wait_cnt + 1;
    guard_req = fire;
    if (fire)
      n_req++;
  end
endmodule

// ==== verification/tb_canopen_port_config_guarding.sv ====
// self-checking bench for the port configuration and guarding block
// assumes cpg_pkg and the master model are compiled first
`timescale 1ns/100ps
module tb_canopen_port_config_guarding;
  import cpg_pkg::*;
  localparam int MS_P = 10;
  logic       core_clk;
  logic       reset_n;
  cpg_req_t   par_req;
  cpg_rsp_t   par_rsp;
  logic [6:0] dip_node;
  logic [2:0] dip_rate;
  logic       guard_req;
  logic       guard_reply;
  logic       guard_fault;
  cpg_cfg_t   port_cfg;
  logic [7:0] cnt_s;
  logic [7:0] cnt_t;
  logic [7:0] cnt_a;
  logic       m_run;
  int         m_gap;
  int         n_req;
  int         n_reply;
  int         n_errors = 0;
  int         num_checks = 0;
  int         cycles = 0;
  cpg_rsp_t   r;

  cpg_top #(.MS_CYCLES_P(MS_P)) u_dut (.core_clk(core_clk), .reset_n(reset_n), .par_req(par_req),
    .par_rsp(par_rsp), .dip_node(dip_node), .dip_rate(dip_rate), .guard_req(guard_req),
    .guard_reply(guard_reply), .guard_fault(guard_fault), .port_cfg(port_cfg),
    .status_group_count(cnt_s), .stored_group_count(cnt_t), .active_group_count(cnt_a));
  cpg_master_model u_master (.core_clk(core_clk), .run(m_run), .gap(m_gap), .guard_req(guard_req),
    .guard_reply(guard_reply), .n_req(n_req), .n_reply(n_reply));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // whole run needs well under two thousand cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  // one request for one edge; the answer is due exactly one cycle later
  task automatic acc(input logic wr, input logic [15:0] addr, input logic [31:0] wd);
    @(posedge core_clk);
    #1;
    par_req = {wr, !wr, addr, wd};
    @(posedge core_clk);
    #1;
    par_req = '0;
    r = par_rsp;
    chk("ack", 32'h1, {31'h0, r.ack});
  endtask

  task automatic wr(input logic [15:0] addr, input logic [31:0] wd, input logic err);
    acc(1'b1, addr, wd);
    chk($sformatf("err of write %h", addr), {31'h0, err}, {31'h0, r.err});
  endtask

  task automatic rd(input logic [15:0] addr, input logic [31:0] exp);
    acc(1'b0, addr, 32'h0);
    chk($sformatf("read %h", addr), exp, r.rdata);
  endtask

  task automatic settle;
    @(posedge core_clk);
    #1;
  endtask

  task automatic do_reset(input logic [6:0] node, input logic [2:0] rate);
    dip_node = node;
    dip_rate = rate;
    reset_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    repeat (10) @(posedge core_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    rd(OFS_PORT_ENABLE, 32'h1);
    rd(OFS_SOURCE_SEL, 32'h0);
    rd(OFS_STORED_NODE, 32'h1);
    rd(OFS_STORED_RATE, 32'h000f4240);
    rd(OFS_ACTIVE_NODE, 32'h1);
    rd(OFS_ACTIVE_RATE, 32'h000f4240);
    rd(OFS_SYNC_ID, 32'h80);
    rd(OFS_SYNC_PERIOD, 32'h0);
    rd(OFS_EMCY_ID, 32'h81);
    chk("emcy_tx_en", 32'h1, {31'h0, port_cfg.emcy_tx_en});
    chk("sync_rx_en", 32'h0, {31'h0, port_cfg.sync_rx_en});
    chk("group counts", 32'h020202, {8'h0, cnt_s, cnt_t, cnt_a});
  endtask

  task automatic t_ranges;
    logic [31:0] rates [7] = '{32'h4e20, 32'hc350, 32'h186a0, 32'h1e848, 32'h3d090, 32'h7a120, 32'hf4240};
    wr(OFS_STORED_NODE, 32'h0, 1'b1);
    wr(OFS_STORED_NODE, 32'h80, 1'b1);
    wr(OFS_STORED_NODE, 32'h7f, 1'b0);
    rd(OFS_STORED_NODE, 32'h7f);
    foreach (rates[i])
    begin
      wr(OFS_STORED_RATE, rates[i], 1'b0);
      rd(OFS_STORED_RATE, rates[i]);
    end
    wr(OFS_STORED_RATE, 32'h1e849, 1'b1);
    rd(OFS_STORED_RATE, 32'hf4240);
    wr(OFS_SOURCE_SEL, 32'h2, 1'b1);
    wr(OFS_SOURCE_SEL, 32'h1, 1'b0);
    rd(OFS_SOURCE_SEL, 32'h1);
    wr(OFS_SYNC_PERIOD, 32'h7d01, 1'b1);
    rd(OFS_SYNC_PERIOD, 32'h0);
    wr(OFS_SYNC_PERIOD, 32'h7d00, 1'b0);
    settle();
    chk("sync_rx_en", 32'h1, {31'h0, port_cfg.sync_rx_en});
    wr(OFS_SYNC_PERIOD, 32'h0, 1'b0);
    settle();
    chk("sync_rx_en", 32'h0, {31'h0, port_cfg.sync_rx_en});
    wr(OFS_ACTIVE_NODE, 32'h5, 1'b1);
    wr(16'h03ec, 32'h0, 1'b1);
    rd(OFS_ACTIVE_NODE, 32'h1);
    wr(OFS_SYNC_ID, 32'h7ff, 1'b0);
    rd(OFS_SYNC_ID, 32'h7ff);
    chk("port_cfg.sync_id", 32'h7ff, port_cfg.sync_id);
  endtask

  task automatic t_emcy;
    wr(OFS_EMCY_ID, 32'h123, 1'b0);
    rd(OFS_EMCY_ID, 32'h81);
    wr(OFS_EMCY_ID, 32'h80000081, 1'b0);
    settle();
    chk("emcy_tx_en", 32'h0, {31'h0, port_cfg.emcy_tx_en});
    wr(OFS_EMCY_ID, 32'h80000123, 1'b0);
    wr(OFS_EMCY_ID, 32'h123, 1'b0);
    rd(OFS_EMCY_ID, 32'h123);
    chk("emcy_tx_en", 32'h1, {31'h0, port_cfg.emcy_tx_en});
  endtask

  task automatic t_port;
    int k;
    wr(OFS_PORT_ENABLE, 32'h0, 1'b0);
    settle();
    chk("port_on", 32'h0, {31'h0, port_cfg.port_on});
    k = n_reply;
    m_gap = 7;
    m_run = 1'b1;
    repeat (40) @(posedge core_clk);
    #1;
    m_run = 1'b0;
    settle();
    chk("replies while off", k, n_reply);
    wr(OFS_PORT_ENABLE, 32'h100, 1'b0);
    settle();
    chk("port_on", 32'h1, {31'h0, port_cfg.port_on});
  endtask

  // timeout is 2 ms times 3 at ten cycles a millisecond: sixty cycles
  task automatic t_guard;
    int q0;
    int p0;
    wr(OFS_GUARD_TIME, 32'h2, 1'b0);
    wr(OFS_LIFE_MULT, 32'h3, 1'b0);
    q0 = n_req;
    p0 = n_reply;
    m_gap = 40;
    m_run = 1'b1;
    repeat (200) @(posedge core_clk);
    @(posedge core_clk iff guard_req === 1'b1);
    #1;
    m_run = 1'b0;
    repeat (55) @(posedge core_clk);
    #1;
    chk("guard replies", n_req - q0, n_reply - p0);
    chk("guard_fault early", 32'h0, {31'h0, guard_fault});
    repeat (20) @(posedge core_clk);
    #1;
    chk("guard_fault late", 32'h1, {31'h0, guard_fault});
  endtask

  task automatic t_source;
    wr(OFS_STORED_NODE, 32'h5, 1'b0);
    rd(OFS_ACTIVE_NODE, 32'h1);
    do_reset(7'h09, 3'h3);
    chk("guard_fault", 32'h0, {31'h0, guard_fault});
    rd(OFS_ACTIVE_NODE, 32'h9);
    rd(OFS_ACTIVE_RATE, 32'h1e848);
    rd(OFS_EMCY_ID, 32'h89);
    chk("port_cfg.node", 32'h9, {16'h0, port_cfg.node});
    chk("port_cfg.rate", 32'h1e848, port_cfg.rate);
    chk("port_cfg.emcy_id", 32'h89, port_cfg.emcy_id);
    do_reset(7'h00, 3'h3);
    rd(OFS_ACTIVE_NODE, 32'h1);
    rd(OFS_ACTIVE_RATE, 32'hf4240);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    par_req = '0;
    m_run = 1'b0;
    m_gap = 10;
    do_reset(7'h00, 3'h0);
    t_defaults();
    t_ranges();
    t_emcy();
    t_port();
    t_guard();
    t_source();
    final_report();
  end
endmodule
